/* File: logic/tcm_channel.sv */
// Channel one mode control: compare output, capture input, filter, prescaler, APB registers
`timescale 1ns/1ps
`include "tcm_map.svh"

module tcm_channel
  import tcm_pkg::*;
#(
  parameter int CNT_W   = 16,
  parameter int DTS_DIV = 1    // Internal clocks per dead time sample clock
)(
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             nrst_i,
  // APB slave
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [7:0]       paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic      [31:0]      prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  // Timer core
  input  wire logic [CNT_W-1:0] counter_i,
  input  wire logic             trigger_i,
  // Pins
  input  wire logic             timer_input_one_i,
  output logic                  compare_out_o,
  output logic                  capture_o,
  // Interrupt
  output logic                  irq_o
);

  // Filter code to sample rate and sample count
  function automatic tcm_filt_cfg_s filt_decode(input logic [3:0] code);
    tcm_filt_cfg_s c;
    c = '{use_ck_int: 1'b0, div_log2: 3'h0, n_samples: 4'h1};
    case (code)
      4'h0: c = '{use_ck_int: 1'b0, div_log2: 3'h0, n_samples: 4'h1};
      4'h1: c = '{use_ck_int: 1'b1, div_log2: 3'h0, n_samples: 4'h2};
      4'h2: c = '{use_ck_int: 1'b1, div_log2: 3'h0, n_samples: 4'h8};
      4'h3: c = '{use_ck_int: 1'b1, div_log2: 3'h0, n_samples: 4'h8};
      4'h4: c = '{use_ck_int: 1'b0, div_log2: 3'h1, n_samples: 4'h6};
      4'h5: c = '{use_ck_int: 1'b0, div_log2: 3'h1, n_samples: 4'h8};
      4'h6: c = '{use_ck_int: 1'b0, div_log2: 3'h2, n_samples: 4'h6};
      4'h7: c = '{use_ck_int: 1'b0, div_log2: 3'h2, n_samples: 4'h8};
      4'h8: c = '{use_ck_int: 1'b0, div_log2: 3'h3, n_samples: 4'h6};
      4'h9: c = '{use_ck_int: 1'b0, div_log2: 3'h3, n_samples: 4'h8};
      4'hA: c = '{use_ck_int: 1'b0, div_log2: 3'h4, n_samples: 4'h5};
      4'hB: c = '{use_ck_int: 1'b0, div_log2: 3'h4, n_samples: 4'h6};
      4'hC: c = '{use_ck_int: 1'b0, div_log2: 3'h4, n_samples: 4'h8};
      4'hD: c = '{use_ck_int: 1'b0, div_log2: 3'h5, n_samples: 4'h5};
      4'hE: c = '{use_ck_int: 1'b0, div_log2: 3'h5, n_samples: 4'h6};
      4'hF: c = '{use_ck_int: 1'b0, div_log2: 3'h5, n_samples: 4'h6};
      default: c = '{use_ck_int: 1'b0, div_log2: 3'h0, n_samples: 4'h1};
    endcase
    return c;
  endfunction

  // Power-of-two count minus one, for divider and prescaler masks
  function automatic logic [4:0] low_mask(input logic [2:0] log2);
    return 5'(({5'h0, 1'b1} << log2) - 6'h1);
  endfunction

  // Register state
  tcm_apb_req_s                req;
  logic [7:2]                  mode_hi;
  logic [1:0]                  dir_sel;
  logic                        chan_en;
  logic [CNT_W-1:0]            compare_value;
  logic [CNT_W-1:0]            capture_value;
  logic [`TCM_ST_W-1:0]        status;
  logic [`TCM_ST_W-1:0]        mask;
  logic                        wr_stb;
  logic                        addr_ok;
  logic [`TCM_ST_W-1:0]        set_evt;

  // Decoded mode fields
  logic [2:0]                  oc_mode;
  logic                        is_out;
  logic                        is_in;
  logic                        is_pwm;
  logic                        fast_eff;
  tcm_filt_cfg_s               fcfg;

  assign req     = '{sel: psel_i, enable: penable_i, write: pwrite_i,
                     addr: paddr_i, wdata: pwdata_i};
  assign oc_mode = mode_hi[`TCM_OCM_MSB:`TCM_OCM_LSB];
  assign is_out  = (dir_sel == `TCM_DIR_OUT);
  assign is_in   = (dir_sel == `TCM_DIR_IN_T1);
  assign is_pwm  = (oc_mode == `TCM_OCM_PWM_ONE) || (oc_mode == `TCM_OCM_PWM_TWO);
  assign fast_eff = mode_hi[`TCM_FAST_BIT] && is_pwm && is_out;
  assign fcfg    = filt_decode(mode_hi[`TCM_FILT_MSB:`TCM_FILT_LSB]);

  // APB decode; zero wait states, unmapped offsets answer with an error
  assign addr_ok = (req.addr == `TCM_OFF_MODE)    || (req.addr == `TCM_OFF_ENABLE)  ||
                   (req.addr == `TCM_OFF_COMPARE) || (req.addr == `TCM_OFF_CAPTURE) ||
                   (req.addr == `TCM_OFF_STATUS)  || (req.addr == `TCM_OFF_MASK);
  assign pready_o  = 1'b1;
  assign pslverr_o = req.sel && req.enable && !addr_ok;
  assign wr_stb    = req.sel && req.enable && req.write && addr_ok;

  // Mode and direction fields
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_hi <= 6'h00;
      dir_sel <= 2'h0;
    end else if (wr_stb && req.addr == `TCM_OFF_MODE) begin
      mode_hi <= req.wdata[7:2];
      if (!chan_en) begin
        dir_sel <= req.wdata[`TCM_DIR_MSB:`TCM_DIR_LSB];
      end
    end
  end

  // Enable, compare value and mask
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chan_en       <= `TCM_RST_ENABLE;
      compare_value <= '0;
      mask          <= '0;
    end else if (wr_stb) begin
      if (req.addr == `TCM_OFF_ENABLE) begin
        chan_en <= req.wdata[0];
      end
      if (req.addr == `TCM_OFF_COMPARE) begin
        compare_value <= req.wdata[CNT_W-1:0];
      end
      if (req.addr == `TCM_OFF_MASK) begin
        mask <= req.wdata[`TCM_ST_W-1:0];
      end
    end
  end

  // Sticky status, write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status <= '0;
    end else if (wr_stb && req.addr == `TCM_OFF_STATUS) begin
      status <= (status & ~req.wdata[`TCM_ST_W-1:0]) | set_evt;
    end else begin
      status <= status | set_evt;
    end
  end

  assign irq_o = |(status & mask);

  // Read data captured in the setup phase so it stands through the access phase
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_o <= 32'h0;
    end else if (req.sel && !req.enable && !req.write) begin
      case (req.addr)
        `TCM_OFF_MODE: begin
          if (is_in) begin
            prdata_o <= {24'h0, mode_hi, dir_sel};
          end else begin
            prdata_o <= {24'h0, 1'b0, mode_hi[6:2], dir_sel};
          end
        end
        `TCM_OFF_ENABLE:  prdata_o <= {31'h0, chan_en};
        `TCM_OFF_COMPARE: prdata_o <= 32'(compare_value);
        `TCM_OFF_CAPTURE: prdata_o <= 32'(capture_value);
        `TCM_OFF_STATUS:  prdata_o <= {{(32-`TCM_ST_W){1'b0}}, status};
        `TCM_OFF_MASK:    prdata_o <= {{(32-`TCM_ST_W){1'b0}}, mask};
        default:          prdata_o <= 32'h0;
      endcase
    end
  end

  // ---------------- Compare path ----------------
  logic [1:0] trig_q;
  logic [1:0] lt_q;
  logic       match_q;
  logic       ref_lvl;
  logic       next_ref;
  logic       last_lt;
  logic [2:0] last_mode;
  logic       fast_hit;
  logic       pwm_level;

  // Trigger pipeline; two stages plus the output flop give the fast latency
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_q <= 2'h0;
    end else begin
      trig_q <= {trig_q[0], trigger_i};
    end
  end

  // Less-than comparison is pipelined twice and the match once, so a counter restart reaches the pin late
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lt_q    <= 2'h0;
      match_q <= 1'b0;
    end else begin
      lt_q    <= {lt_q[0], counter_i < compare_value};
      match_q <= (counter_i == compare_value);
    end
  end

  assign fast_hit  = trig_q[1] && fast_eff;
  assign pwm_level = (oc_mode == `TCM_OCM_PWM_ONE) ? lt_q[1] : !lt_q[1];

  // Next reference level by compare mode
  always_comb begin
    next_ref = ref_lvl;
    case (oc_mode)
      `TCM_OCM_FROZEN:   next_ref = ref_lvl;
      `TCM_OCM_SET:      next_ref = match_q ? 1'b1 : ref_lvl;
      `TCM_OCM_CLEAR:    next_ref = match_q ? 1'b0 : ref_lvl;
      `TCM_OCM_TOGGLE:   next_ref = match_q ? !ref_lvl : ref_lvl;
      `TCM_OCM_FORCE_LO: next_ref = 1'b0;
      `TCM_OCM_FORCE_HI: next_ref = 1'b1;
      `TCM_OCM_PWM_ONE,
      `TCM_OCM_PWM_TWO: begin
        if (fast_hit) begin
          // Match level: PWM one goes inactive, PWM two active
          next_ref = (oc_mode == `TCM_OCM_PWM_TWO);
        end else if (lt_q[1] != last_lt || oc_mode != last_mode) begin
          next_ref = pwm_level;
        end
      end
      default:           next_ref = ref_lvl;
    endcase
  end

  // Reference and pin; PWM levels move when the comparison result or the mode changes, or on a fast trigger
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ref_lvl       <= 1'b0;
      last_lt       <= 1'b0;
      last_mode     <= 3'h0;
      compare_out_o <= 1'b0;
    end else begin
      ref_lvl       <= next_ref;
      last_lt       <= lt_q[1];
      last_mode     <= oc_mode;
      compare_out_o <= next_ref && chan_en && is_out;
    end
  end

  // ---------------- Capture path ----------------
  logic [15:0] dts_cnt;
  logic        dts_tick;
  logic [4:0]  slow_cnt;
  logic        sample_tick;
  logic        filt_out;
  logic        filt_q;
  logic        edge_evt;
  logic [2:0]  psc_cnt;
  logic [2:0]  psc_top;
  logic        cap_evt;

  // Dead time sample clock as a one-cycle enable, plus a slow count for its divisions
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dts_cnt  <= 16'h0;
      slow_cnt <= 5'h0;
    end else if (dts_cnt == 16'(DTS_DIV - 1)) begin
      dts_cnt  <= 16'h0;
      slow_cnt <= slow_cnt + 5'h1;
    end else begin
      dts_cnt  <= dts_cnt + 16'h1;
    end
  end

  assign dts_tick    = (dts_cnt == 16'(DTS_DIV - 1));
  assign sample_tick = fcfg.use_ck_int ||
                       (dts_tick && ((slow_cnt & low_mask(fcfg.div_log2)) == 5'h0));

  tcm_filter u_filter (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .sample_i    (sample_tick),
    .n_samples_i (fcfg.n_samples),
    .din_i       (timer_input_one_i),
    .dout_o      (filt_out)
  );

  // Rising edge of the filtered input, only while enabled as a capture input
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      filt_q <= 1'b0;
    end else begin
      filt_q <= filt_out;
    end
  end

  assign edge_evt = filt_out && !filt_q && chan_en && is_in;
  assign psc_top  = 3'(low_mask({1'b0, mode_hi[`TCM_PSC_MSB:`TCM_PSC_LSB]}));
  assign cap_evt  = edge_evt && (psc_cnt >= psc_top);

  // Prescaler count; cleared while the channel is off
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      psc_cnt <= 3'h0;
    end else if (!chan_en) begin
      psc_cnt <= 3'h0;
    end else if (edge_evt) begin
      psc_cnt <= cap_evt ? 3'h0 : psc_cnt + 3'h1;
    end
  end

  // Capture latch and pulse
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      capture_value <= '0;
      capture_o     <= 1'b0;
    end else begin
      capture_o <= cap_evt;
      if (cap_evt) begin
        capture_value <= counter_i;
      end
    end
  end

  // Events into the status register
  always_comb begin
    set_evt                 = '0;
    set_evt[`TCM_ST_CAPTURE] = cap_evt;
    set_evt[`TCM_ST_MATCH]   = match_q && chan_en && is_out;
  end

endmodule

/* File: logic/tcm_map.svh */
// Register map, field positions, reset values and timing counts of the channel one mode block
`ifndef TCM_MAP_SVH
`define TCM_MAP_SVH

// Register byte offsets
`define TCM_OFF_MODE      8'h00
`define TCM_OFF_ENABLE    8'h04
`define TCM_OFF_COMPARE   8'h08
`define TCM_OFF_CAPTURE   8'h0C
`define TCM_OFF_STATUS    8'h10
`define TCM_OFF_MASK      8'h14

// Mode register fields
`define TCM_DIR_LSB       0
`define TCM_DIR_MSB       1
`define TCM_FAST_BIT      2
`define TCM_PSC_LSB       2
`define TCM_PSC_MSB       3
`define TCM_OCM_LSB       4
`define TCM_OCM_MSB       6
`define TCM_FILT_LSB      4
`define TCM_FILT_MSB      7

// Direction selector codes
`define TCM_DIR_OUT       2'h0
`define TCM_DIR_IN_T1     2'h1

// Compare mode codes
`define TCM_OCM_FROZEN    3'h0
`define TCM_OCM_SET       3'h1
`define TCM_OCM_CLEAR     3'h2
`define TCM_OCM_TOGGLE    3'h3
`define TCM_OCM_FORCE_LO  3'h4
`define TCM_OCM_FORCE_HI  3'h5
`define TCM_OCM_PWM_ONE   3'h6
`define TCM_OCM_PWM_TWO   3'h7

// Status and mask bits
`define TCM_ST_CAPTURE    0
`define TCM_ST_MATCH      1
`define TCM_ST_W          2

// Reset values
`define TCM_RST_MODE      8'h00
`define TCM_RST_ENABLE    1'b0

// Trigger to output latencies in clock cycles
`define TCM_FAST_LAT      3
`define TCM_NORM_LAT      5

`endif

/* File: logic/tcm_pkg.sv */
// Types shared by the channel one mode block
package tcm_pkg;

  // Filter setting decoded from the filter code
  typedef struct packed {
    logic       use_ck_int;  // Sample every internal clock
    logic [2:0] div_log2;    // Divider of the dead time sample clock, as a power of two
    logic [3:0] n_samples;   // Agreeing samples needed
  } tcm_filt_cfg_s;

  // APB request bundle
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } tcm_apb_req_s;

endpackage

/* File: logic/tcm_filter.sv */
// Digital event-counter filter for the timer input
`timescale 1ns/1ps
`include "tcm_map.svh"

module tcm_filter
  import tcm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  // Sampling control
  input  wire logic       sample_i,
  input  wire logic [3:0] n_samples_i,
  // Data
  input  wire logic       din_i,
  output logic            dout_o
);

  logic [3:0] agree_cnt;

  // Count consecutive samples that differ from the output; any agreeing sample restarts
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      agree_cnt <= 4'h0;
      dout_o    <= 1'b0;
    end else if (sample_i) begin
      if (din_i == dout_o) begin
        agree_cnt <= 4'h0;
      end else if (agree_cnt + 4'h1 >= n_samples_i) begin
        dout_o    <= din_i;
        agree_cnt <= 4'h0;
      end else begin
        agree_cnt <= agree_cnt + 4'h1;
      end
    end
  end

endmodule

/* File: tb/tcm_channel_assertions.sv */
// Port checker for the channel one mode block
`timescale 1ns/1ps
`include "tcm_map.svh"
module tcm_channel_assertions #(
  parameter int CNT_W = 16
)(
  // Clock, reset and APB
  input wire logic             clk_sys_i,
  input wire logic             nrst_i,
  input wire logic             psel_i,
  input wire logic             penable_i,
  input wire logic             pwrite_i,
  input wire logic [7:0]       paddr_i,
  input wire logic [31:0]      pwdata_i,
  input wire logic [31:0]      prdata_o,
  input wire logic             pready_o,
  input wire logic             pslverr_o,
  // Timer, pins and interrupt
  input wire logic [CNT_W-1:0] counter_i,
  input wire logic             trigger_i,
  input wire logic             timer_input_one_i,
  input wire logic             compare_out_o,
  input wire logic             capture_o,
  input wire logic             irq_o
);
  logic [7:0]       mode_q;
  logic             en_q;
  logic [1:0]       mask_q;
  logic [3:0]       quiet_q;
  logic [CNT_W-1:0] cnt_d;
  logic             out_ok;
  logic             cap_ok;
  logic             fast_eff;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  // Shadow of the controls; direction frozen while enabled
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_q <= 8'h00;
      en_q   <= 1'b0;
      mask_q <= 2'h0;
    end else if (psel_i && penable_i && pwrite_i) begin
      if (paddr_i == `TCM_OFF_MODE) begin
        mode_q <= {pwdata_i[7:2], en_q ? mode_q[1:0] : pwdata_i[1:0]};
      end
      if (paddr_i == `TCM_OFF_ENABLE) begin
        en_q <= pwdata_i[0];
      end
      if (paddr_i == `TCM_OFF_MASK) begin
        mask_q <= pwdata_i[1:0];
      end
    end
  end

  // Quiet cycles, so pipeline traffic from older changes has drained
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      quiet_q <= 4'h0;
      cnt_d   <= '0;
    end else begin
      cnt_d <= counter_i;
      if (psel_i || counter_i != cnt_d) begin
        quiet_q <= 4'h0;
      end else if (quiet_q != 4'hF) begin
        quiet_q <= quiet_q + 4'h1;
      end
    end
  end

  assign out_ok   = en_q && mode_q[1:0] == `TCM_DIR_OUT;
  assign cap_ok   = en_q && mode_q[1:0] == `TCM_DIR_IN_T1;
  assign fast_eff = out_ok && mode_q[`TCM_FAST_BIT] && mode_q[6:5] == 2'h3;

  sequence s_still;
    !psel_i && $stable(counter_i);
  endsequence
  sequence s_fast_trig;
    trigger_i && fast_eff && quiet_q > 4'h3;
  endsequence
  sequence s_slow_trig;
    trigger_i && !fast_eff && mode_q[6] && quiet_q > 4'h3;
  endsequence

  a_ready_zero_wait: assert property (psel_i && penable_i |-> pready_o)
    else $error("pready low in access phase");
  a_err_unmapped: assert property (psel_i && penable_i |->
    pslverr_o == (paddr_i[1:0] != 2'h0 || paddr_i > `TCM_OFF_MASK))
    else $error("pslverr wrong for address");
  a_mode_readback: assert property (
    psel_i && penable_i && !pwrite_i && paddr_i == `TCM_OFF_MODE |->
    prdata_o == {24'h0, cap_ok || mode_q[1:0] == `TCM_DIR_IN_T1 ? mode_q[7] : 1'b0,
    mode_q[6:0]})
    else $error("mode register read wrong");
  a_fast_level: assert property (
    s_fast_trig ##1 s_still [*3] |-> ##[0:1] compare_out_o == mode_q[4])
    else $error("fast trigger did not force level");
  a_slow_no_change: assert property (
    s_slow_trig ##1 s_still [*4] |-> compare_out_o == $past(compare_out_o, 4))
    else $error("trigger moved output without fast path");
  a_out_gated: assert property (
    compare_out_o |-> out_ok || $past(out_ok) || $past(out_ok, 2))
    else $error("output active while not an enabled output");
  a_capture_gated: assert property (
    capture_o |-> $past(cap_ok) || $past(cap_ok, 2))
    else $error("capture while not an enabled input");
  a_capture_single: assert property (capture_o |=> !capture_o)
    else $error("capture pulse too long");
  a_irq_masked: assert property (irq_o |-> mask_q != 2'h0)
    else $error("interrupt with all sources masked");
endmodule

bind tcm_channel tcm_channel_assertions #(.CNT_W(CNT_W)) u_chk (
  .clk_sys_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
  .pready_o, .pslverr_o, .counter_i, .trigger_i, .timer_input_one_i, .compare_out_o,
  .capture_o, .irq_o
);

/* File: tb/tcm_pin_model.sv */
// Outside driver of the timer input pin
`timescale 1ns/1ps
module tcm_pin_model (
  // Clock
  input  wire logic clk_sys_i,
  // Pin
  output logic      pin_o
);
  // Pin rests low between pulses
  initial pin_o = 1'b0;

  // Pulse train; levels move just after a rising edge
  task automatic send(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      pin_o <= 1'b1;
      repeat (hi) @(posedge clk_sys_i);
      pin_o <= 1'b0;
      repeat (lo) @(posedge clk_sys_i);
    end
  endtask
endmodule

/* File: tb/tb_timer_channel_one_mode_control.sv */
// Self-checking bench for the channel one mode block
`timescale 1ns/1ps
`include "tcm_map.svh"
module tb_timer_channel_one_mode_control;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h0;
  logic [15:0] counter_i = 16'h0;
  logic        trigger_i = 1'b0;
  logic        timer_input_one_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        compare_out_o;
  logic        capture_o;
  logic        irq_o;
  logic [31:0] rd_v;
  logic        err_v;
  logic        out_s;
  int          miscompares = 0;
  int          tests_run   = 0;
  int          caps        = 0;
  int          cycles      = 0;
  int          c0;
  int          n;
  int          pr;
  // Mode, then level before and after a trigger
  logic [9:0]  cmp_tab [5] = '{{8'h64, 2'h2}, {8'h74, 2'h1}, {8'h60, 2'h3},
                               {8'h54, 2'h3}, {8'h44, 2'h0}};
  // Filter code, samples needed, clocks per sample
  logic [15:0] flt_tab [9] = '{16'h0101, 16'h1201, 16'h2801, 16'h4602, 16'h5802,
                               16'hA510, 16'hC810, 16'hD520, 16'hE620};

  tcm_channel #(.CNT_W(16), .DTS_DIV(1)) DUT (
    .clk_sys_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .counter_i, .trigger_i, .timer_input_one_i, .compare_out_o,
    .capture_o, .irq_o
  );
  tcm_pin_model pin (.clk_sys_i, .pin_o(timer_input_one_i));

  // 125 MHz clock
  initial forever #4 clk_sys_i = ~clk_sys_i;

  // Settled copies, taken mid-cycle away from the launching edge
  always @(negedge clk_sys_i) begin
    out_s <= compare_out_o;
    if (capture_o === 1'b1) caps <= caps + 1;
  end

  // Hang guard
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rd_v = prdata_o;
    err_v = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rd_v, exp);
    chk("pslverr", {31'h0, err_v}, {31'h0, err});
  endtask

  task automatic chk_out(input logic exp);
    chk("compare_out", {31'h0, out_s}, {31'h0, exp});
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    // Reset values, then an unmapped word
    for (int a = 0; a < 6; a++) rd(8'(a * 4), 32'h0, 1'b0);
    rd(8'h18, 32'h0, 1'b1);
    // Field views and the direction lock
    wr(`TCM_OFF_MODE, 32'hFFFFFFFC);
    rd(`TCM_OFF_MODE, 32'h7C, 1'b0);
    wr(`TCM_OFF_MODE, 32'hFD);
    rd(`TCM_OFF_MODE, 32'hFD, 1'b0);
    wr(`TCM_OFF_ENABLE, 32'h1);
    wr(`TCM_OFF_MODE, 32'h0);
    rd(`TCM_OFF_MODE, 32'h1, 1'b0);
    wr(`TCM_OFF_ENABLE, 32'h0);
    wr(`TCM_OFF_MODE, 32'h0);
    rd(`TCM_OFF_MODE, 32'h0, 1'b0);
    // Trigger response in the PWM and forced compare modes, counter below compare, then PWM one with the counter above
    wr(`TCM_OFF_COMPARE, 32'h10);
    wr(`TCM_OFF_ENABLE, 32'h1);
    foreach (cmp_tab[i]) begin
      wr(`TCM_OFF_MODE, 32'h0);
      wr(`TCM_OFF_MODE, {24'h0, cmp_tab[i][9:2]});
      repeat (6) @(posedge clk_sys_i);
      chk_out(cmp_tab[i][1]);
      trigger_i <= 1'b1;
      @(posedge clk_sys_i);
      trigger_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      chk_out(cmp_tab[i][1]);
      @(posedge clk_sys_i);
      chk_out(cmp_tab[i][0]);
      repeat (4) @(posedge clk_sys_i);
      chk_out(cmp_tab[i][0]);
    end
    counter_i <= 16'h20;
    wr(`TCM_OFF_MODE, 32'h0);
    wr(`TCM_OFF_MODE, 32'h60);
    repeat (5) @(posedge clk_sys_i);
    chk_out(1'b0);
    // Match flag; a match in the clear cycle keeps it set
    counter_i <= 16'h10;
    repeat (3) @(posedge clk_sys_i);
    wr(`TCM_OFF_STATUS, 32'h2);
    rd(`TCM_OFF_STATUS, 32'h2, 1'b0);
    counter_i <= 16'h20;
    repeat (3) @(posedge clk_sys_i);
    wr(`TCM_OFF_STATUS, 32'h2);
    rd(`TCM_OFF_STATUS, 32'h0, 1'b0);
    // Capture input, prescaler ratios over eight edges
    wr(`TCM_OFF_ENABLE, 32'h0);
    counter_i <= 16'h1234;
    wr(`TCM_OFF_MODE, 32'h1);
    wr(`TCM_OFF_ENABLE, 32'h1);
    for (int p = 0; p < 4; p++) begin
      wr(`TCM_OFF_MODE, 32'(p * 4 + 1));
      c0 = caps;
      pin.send(8, 4, 4);
      repeat (8) @(posedge clk_sys_i);
      chk("captures", caps - c0, 32'(8 >> p));
    end
    // Disabling mid-count restarts the divide by eight
    c0 = caps;
    pin.send(4, 4, 4);
    wr(`TCM_OFF_ENABLE, 32'h0);
    wr(`TCM_OFF_ENABLE, 32'h1);
    pin.send(4, 4, 4);
    repeat (8) @(posedge clk_sys_i);
    chk("captures", caps - c0, 32'h0);
    pin.send(4, 4, 4);
    repeat (8) @(posedge clk_sys_i);
    chk("captures", caps - c0, 32'h1);
    // Captured value, read-only capture, sticky status and interrupt
    rd(`TCM_OFF_CAPTURE, 32'h1234, 1'b0);
    wr(`TCM_OFF_CAPTURE, 32'h0);
    rd(`TCM_OFF_CAPTURE, 32'h1234, 1'b0);
    rd(`TCM_OFF_STATUS, 32'h1, 1'b0);
    chk("irq", {31'h0, irq_o}, 32'h0);
    wr(`TCM_OFF_MASK, 32'h1);
    chk("irq", {31'h0, irq_o}, 32'h1);
    wr(`TCM_OFF_STATUS, 32'h1);
    chk("irq", {31'h0, irq_o}, 32'h0);
    rd(`TCM_OFF_STATUS, 32'h0, 1'b0);
    // Filter: one sample short is dropped, a long pulse is taken
    foreach (flt_tab[i]) begin
      wr(`TCM_OFF_MODE, {24'h0, flt_tab[i][15:12], 4'h1});
      n = int'(flt_tab[i][11:8]);
      pr = int'(flt_tab[i][7:0]);
      c0 = caps;
      if (n > 1) pin.send(1, (n - 2) * pr + 1, (n + 2) * pr + 4);
      chk("captures", caps - c0, 32'h0);
      pin.send(1, (n + 2) * pr + 4, (n + 2) * pr + 4);
      chk("captures", caps - c0, 32'h1);
    end
    end_of_test();
  end
endmodule
